// file: include/link_cfg_defines.svh
// offsets, field positions, reset values and masks of the link parameter bank
`ifndef LINK_CFG_DEFINES_SVH
`define LINK_CFG_DEFINES_SVH
`define LANE_CFG_IDX     12'h58B
`define OCTET_CFG_IDX    12'h58C
`define FRAME_CFG_IDX    12'h58D
`define CONV_CFG_IDX     12'h58E
`define CTRL_CFG_IDX     12'h58F
`define SCRAMBLER_BIT    7
`define SCRAMBLER_RST    1'h1
`define LANE_CNT_RST     5'h07
`define OCTET_CNT_RST    8'h00
`define FRAME_CNT_RST    5'h1F
`define CONV_CNT_RST     8'h01
`define CTRL_BITS_RST    2'h0
`define RESOLUTION_RST   5'h0F
`define LANE_CFG_MASK    8'h9F
`define OCTET_CFG_MASK   8'hFF
`define FRAME_CFG_MASK   8'h1F
`define CONV_CFG_MASK    8'hFF
`define CTRL_CFG_MASK    8'hDF
`define UNMAPPED_RDATA   32'h00000000
`endif

// file: include/link_cfg_pkg.sv
// types of the link parameter bank
package link_cfg_pkg;
	typedef struct packed {
		logic       scrambler_on;
		logic [4:0] lane_cnt;
		logic [7:0] octet_cnt;
		logic [4:0] frame_cnt;
		logic [7:0] conv_cnt;
		logic [1:0] ctrl_bits;
		logic [4:0] resolution;
	} link_cfg_s;

	typedef struct packed {
		link_cfg_s   cfg;
		logic        waitreq;
		logic [31:0] rdata;
	} bank_state_s;

	typedef enum logic [2:0] {
		REG_LANE  = 3'h0,
		REG_OCTET = 3'h1,
		REG_FRAME = 3'h2,
		REG_CONV  = 3'h3,
		REG_CTRL  = 3'h4,
		REG_NONE  = 3'h7
	} reg_sel_e;
endpackage

// file: core/link_cfg_decode.sv
// word address decoder of the link parameter bank
`timescale 1ns/10ps
`include "link_cfg_defines.svh"
module link_cfg_decode (
	input  wire logic [13:0]           byte_addr_i,
	output link_cfg_pkg::reg_sel_e     sel_o
);
	logic [11:0] idx;
	assign idx = byte_addr_i[13:2];
	always_comb begin
		unique case (idx)
			`LANE_CFG_IDX:  sel_o = link_cfg_pkg::REG_LANE;
			`OCTET_CFG_IDX: sel_o = link_cfg_pkg::REG_OCTET;
			`FRAME_CFG_IDX: sel_o = link_cfg_pkg::REG_FRAME;
			`CONV_CFG_IDX:  sel_o = link_cfg_pkg::REG_CONV;
			`CTRL_CFG_IDX:  sel_o = link_cfg_pkg::REG_CTRL;
			default:        sel_o = link_cfg_pkg::REG_NONE;
		endcase
	end
endmodule

// file: core/serial_link_param_config.sv
// register bank holding the framing parameters of the serial output link
`timescale 1ns/10ps
`include "link_cfg_defines.svh"
module serial_link_param_config (
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_i,
	input  wire logic [13:0]               avs_address_i,
	input  wire logic                      avs_read_i,
	input  wire logic                      avs_write_i,
	input  wire logic [31:0]               avs_writedata_i,
	input  wire logic [3:0]                avs_byteenable_i,
	output logic      [31:0]               avs_readdata_o,
	output logic                           avs_waitrequest_o,
	output link_cfg_pkg::link_cfg_s        link_cfg_o
);
	link_cfg_pkg::bank_state_s state_q;
	link_cfg_pkg::bank_state_s state_d;
	link_cfg_pkg::reg_sel_e    sel;
	logic [7:0]                wbyte;
	logic                      wr_en;

	link_cfg_decode decode_u (
		.byte_addr_i (avs_address_i),
		.sel_o       (sel)
	);

	// register image as read back; reserved positions are forced to zero
	function automatic logic [7:0] reg_image(input link_cfg_pkg::link_cfg_s c,
		input link_cfg_pkg::reg_sel_e s);
		logic [7:0] v;
		v = 8'h00;
		unique case (s)
			link_cfg_pkg::REG_LANE:  v = {c.scrambler_on, 2'h0, c.lane_cnt};
			link_cfg_pkg::REG_OCTET: v = c.octet_cnt;
			link_cfg_pkg::REG_FRAME: v = {3'h0, c.frame_cnt};
			link_cfg_pkg::REG_CONV:  v = c.conv_cnt;
			link_cfg_pkg::REG_CTRL:  v = {c.ctrl_bits, 1'b0, c.resolution};
			default:                 v = 8'h00;
		endcase
		return v;
	endfunction

	// only byte lane 0 carries data; a write without it is dropped
	assign wbyte = avs_writedata_i[7:0];
	// a write lands only at the edge where waitrequest is low, so a stalled write never lands twice
	assign wr_en = avs_write_i && avs_byteenable_i[0] && !state_q.waitreq;

	always_comb begin
		state_d = state_q;
		// every request waits one cycle; an idle bus also sees waitrequest high
		state_d.waitreq = 1'b1;
		if ((avs_read_i || avs_write_i) && state_q.waitreq) begin
			state_d.waitreq = 1'b0;
		end
		if (wr_en) begin
			unique case (sel)
				link_cfg_pkg::REG_LANE: begin
					state_d.cfg.scrambler_on = wbyte[`SCRAMBLER_BIT];
					state_d.cfg.lane_cnt = wbyte[4:0];
				end
				link_cfg_pkg::REG_OCTET: state_d.cfg.octet_cnt = wbyte;
				link_cfg_pkg::REG_FRAME: state_d.cfg.frame_cnt = wbyte[4:0];
				link_cfg_pkg::REG_CONV:  state_d.cfg.conv_cnt = wbyte;
				link_cfg_pkg::REG_CTRL: begin
					state_d.cfg.ctrl_bits = wbyte[7:6];
					state_d.cfg.resolution = wbyte[4:0];
				end
				default: state_d.cfg = state_q.cfg;
			endcase
		end
		// read data is loaded in the wait cycle and stands while waitrequest is low
		if (avs_read_i && state_q.waitreq) begin
			state_d.rdata = {24'h000000, reg_image(state_q.cfg, sel)};
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q.cfg.scrambler_on <= `SCRAMBLER_RST;
			state_q.cfg.lane_cnt <= `LANE_CNT_RST;
			state_q.cfg.octet_cnt <= `OCTET_CNT_RST;
			state_q.cfg.frame_cnt <= `FRAME_CNT_RST;
			state_q.cfg.conv_cnt <= `CONV_CNT_RST;
			state_q.cfg.ctrl_bits <= `CTRL_BITS_RST;
			state_q.cfg.resolution <= `RESOLUTION_RST;
			// waitrequest stays high in reset so no request is taken
			state_q.waitreq <= 1'b1;
			state_q.rdata <= `UNMAPPED_RDATA;
		end else begin
			state_q <= state_d;
		end
	end

	assign avs_readdata_o = state_q.rdata;
	assign link_cfg_o = state_q.cfg;
	// waitrequest comes from a flop; the price is one wait cycle on writes as well
	assign avs_waitrequest_o = state_q.waitreq;

	// reset seen at two edges in a row; the first edge may still find the bank unset
	sequence rst_held_s;
		rst_i ##1 rst_i;
	endsequence

	// a request that meets waitrequest high
	sequence req_stalled_s;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence

	// the edge at which a read is answered
	sequence rd_answer_s;
		avs_read_i && !avs_write_i && !avs_waitrequest_o;
	endsequence

	sequence wr_lane_s;
		wr_en && sel == link_cfg_pkg::REG_LANE;
	endsequence

	scrambler_reset_a: assert property (@(posedge sys_clk_i)
		rst_held_s |-> link_cfg_o.scrambler_on == `SCRAMBLER_RST)
		else $error("scrambler bit wrong in reset");
	lane_reset_a: assert property (@(posedge sys_clk_i)
		rst_held_s |-> link_cfg_o.lane_cnt == `LANE_CNT_RST)
		else $error("lane count wrong in reset");
	octet_reset_a: assert property (@(posedge sys_clk_i)
		rst_held_s |-> link_cfg_o.octet_cnt == `OCTET_CNT_RST)
		else $error("octet count wrong in reset");
	frame_reset_a: assert property (@(posedge sys_clk_i)
		rst_held_s |-> link_cfg_o.frame_cnt == `FRAME_CNT_RST)
		else $error("frame count wrong in reset");
	conv_reset_a: assert property (@(posedge sys_clk_i)
		rst_held_s |-> link_cfg_o.conv_cnt == `CONV_CNT_RST)
		else $error("converter count wrong in reset");
	ctrl_reset_a: assert property (@(posedge sys_clk_i)
		rst_held_s |-> link_cfg_o.ctrl_bits == `CTRL_BITS_RST)
		else $error("control bit count wrong in reset");
	resolution_reset_a: assert property (@(posedge sys_clk_i)
		rst_held_s |-> link_cfg_o.resolution == `RESOLUTION_RST)
		else $error("resolution wrong in reset");
	wait_reset_a: assert property (@(posedge sys_clk_i)
		rst_held_s |-> avs_waitrequest_o == 1'h1)
		else $error("waitrequest low in reset");

	scrambler_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_lane_s |=> link_cfg_o.scrambler_on == $past(avs_writedata_i[7]))
		else $error("scrambler bit not written");
	lane_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_lane_s |=> link_cfg_o.lane_cnt == $past(avs_writedata_i[4:0]))
		else $error("lane count not written");
	octet_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_en && sel == link_cfg_pkg::REG_OCTET |=> link_cfg_o.octet_cnt == $past(avs_writedata_i[7:0]))
		else $error("octet count not written");
	frame_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_en && sel == link_cfg_pkg::REG_FRAME |=> link_cfg_o.frame_cnt == $past(avs_writedata_i[4:0]))
		else $error("frame count not written");
	conv_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_en && sel == link_cfg_pkg::REG_CONV |=> link_cfg_o.conv_cnt == $past(avs_writedata_i[7:0]))
		else $error("converter count not written");
	ctrl_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_en && sel == link_cfg_pkg::REG_CTRL |=> link_cfg_o.ctrl_bits == $past(avs_writedata_i[7:6]))
		else $error("control bit count not written");
	resolution_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_en && sel == link_cfg_pkg::REG_CTRL |=> link_cfg_o.resolution == $past(avs_writedata_i[4:0]))
		else $error("resolution not written");

	// the frame, lane, converter and resolution fields do not move without a write that lands on that register
	frame_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!(wr_en && sel == link_cfg_pkg::REG_FRAME) |=> $stable(link_cfg_o.frame_cnt))
		else $error("frame count changed without write");
	lane_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!(wr_en && sel == link_cfg_pkg::REG_LANE) |=> $stable(link_cfg_o.lane_cnt))
		else $error("lane count changed without write");
	conv_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!(wr_en && sel == link_cfg_pkg::REG_CONV) |=> $stable(link_cfg_o.conv_cnt))
		else $error("converter count changed without write");
	resolution_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!(wr_en && sel == link_cfg_pkg::REG_CTRL) |=> $stable(link_cfg_o.resolution))
		else $error("resolution changed without write");
	masked_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		avs_write_i && !avs_byteenable_i[0] |=> $stable(link_cfg_o))
		else $error("write without byte lane 0 changed the bank");
	unmapped_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		avs_write_i && sel == link_cfg_pkg::REG_NONE |=> $stable(link_cfg_o))
		else $error("unmapped write changed the bank");

	scrambler_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rd_answer_s ##0 (sel == link_cfg_pkg::REG_LANE) |-> avs_readdata_o[7] == link_cfg_o.scrambler_on)
		else $error("scrambler readback wrong");
	lane_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rd_answer_s ##0 (sel == link_cfg_pkg::REG_LANE) |-> avs_readdata_o[6:0] == {2'h0, link_cfg_o.lane_cnt})
		else $error("lane readback wrong");
	octet_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rd_answer_s ##0 (sel == link_cfg_pkg::REG_OCTET) |-> avs_readdata_o[7:0] == link_cfg_o.octet_cnt)
		else $error("octet readback wrong");
	frame_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rd_answer_s ##0 (sel == link_cfg_pkg::REG_FRAME) |-> avs_readdata_o[7:0] == {3'h0, link_cfg_o.frame_cnt})
		else $error("frame readback wrong");
	conv_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rd_answer_s ##0 (sel == link_cfg_pkg::REG_CONV) |-> avs_readdata_o[7:0] == link_cfg_o.conv_cnt)
		else $error("converter readback wrong");
	ctrl_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rd_answer_s ##0 (sel == link_cfg_pkg::REG_CTRL) |-> avs_readdata_o[7:5] == {link_cfg_o.ctrl_bits, 1'h0})
		else $error("control bit readback wrong");
	unmapped_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rd_answer_s ##0 (sel == link_cfg_pkg::REG_NONE) |-> avs_readdata_o == `UNMAPPED_RDATA)
		else $error("unmapped read not zero");
	resolution_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		avs_read_i && !avs_write_i && sel == link_cfg_pkg::REG_CTRL && !avs_waitrequest_o
		|-> avs_readdata_o[4:0] == link_cfg_o.resolution)
		else $error("resolution readback wrong");
	reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
		else $error("reserved bits not zero");
	read_latency_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("read not answered in one cycle");
	write_latency_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		req_stalled_s ##0 avs_write_i |=> !avs_waitrequest_o)
		else $error("write not answered in one cycle");
	answer_once_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
endmodule

// file: testbench/serial_link_param_config_tb.sv
// self-checking bench of the link parameter bank
`timescale 1ns/10ps
`include "link_cfg_defines.svh"
module serial_link_param_config_tb;
	logic                    sys_clk_i = 1'b0;
	logic                    rst_i = 1'b1;
	logic [13:0]             avs_address_i = 14'h0000;
	logic                    avs_read_i = 1'b0;
	logic                    avs_write_i = 1'b0;
	logic [31:0]             avs_writedata_i = 32'h00000000;
	logic [3:0]              avs_byteenable_i = 4'hF;
	logic [31:0]             avs_readdata_o;
	logic                    avs_waitrequest_o;
	link_cfg_pkg::link_cfg_s link_cfg_o;
	logic [7:0]              exp_q [5];
	logic [7:0]              mask_t [5];
	logic [7:0]              code_t [9];
	logic [31:0]             note_q [$];
	int                      errors = 0;
	int                      tests_run = 0;
	always #25 sys_clk_i = ~sys_clk_i;
	serial_link_param_config DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .link_cfg_o(link_cfg_o));
	task automatic report_and_stop();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp32(string name, logic [31:0] e, logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, e, s);
		end
	endtask
	// fields rebuilt from the byte model, so a field wired to the wrong bits shows here
	task automatic cmp_cfg();
		link_cfg_pkg::link_cfg_s e;
		e = '{exp_q[0][7], exp_q[0][4:0], exp_q[1], exp_q[2][4:0], exp_q[3], exp_q[4][7:6], exp_q[4][4:0]};
		@(negedge sys_clk_i);
		tests_run++;
		if (link_cfg_o !== e) begin
			errors++;
			$display("ERROR link_cfg_o expected %h seen %h", e, link_cfg_o);
		end
	endtask
	// index 5 lands one word past the bank, which is unmapped
	task automatic bus(input logic wr, input int i, input logic [7:0] d, input logic be);
		logic [7:0] dv;
		// frame field kept at three modulo four, so the multiframe length is a multiple of four
		dv = (wr && i == 2) ? (d | 8'h03) : d;
		@(posedge sys_clk_i);
		avs_address_i <= 14'(14'h162C + 4 * i);
		avs_read_i <= !wr;
		avs_write_i <= wr;
		avs_writedata_i <= {24'($urandom), dv};
		avs_byteenable_i <= {3'($urandom), be};
		if (!wr) note_q.push_back(i < 5 ? {24'h000000, exp_q[i]} : `UNMAPPED_RDATA);
		do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (wr && be && i < 5) exp_q[i] = dv & mask_t[i];
	endtask
	always @(posedge sys_clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0) begin
			if (note_q.size() > 0) cmp32("avs_readdata_o", note_q.pop_front(), avs_readdata_o);
			else cmp32("read without note", 32'h00000000, 32'hFFFFFFFF);
		end
	end
	initial begin
		mask_t = '{`LANE_CFG_MASK, `OCTET_CFG_MASK, `FRAME_CFG_MASK, `CONV_CFG_MASK, `CTRL_CFG_MASK};
		code_t = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h07, 8'h0F, 8'h40, 8'h80, 8'hFF};
		exp_q = '{8'h87, 8'h00, 8'h1F, 8'h01, 8'h0F};
		void'($urandom(94));
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		cmp_cfg();
		for (int i = 0; i < 6; i++) bus(1'b0, i, 8'h00, 1'b1);
		foreach (code_t[c]) begin
			for (int i = 0; i < 6; i++) begin
				bus(1'b1, i, code_t[c], 1'b1);
				cmp_cfg();
				bus(1'b0, i, 8'h00, 1'b1);
			end
		end
		// random mix of reads, writes, masked writes and the unmapped word
		repeat (60) bus(1'($urandom_range(1)), $urandom_range(5), 8'($urandom), 1'($urandom_range(1)));
		cmp_cfg();
		@(posedge sys_clk_i);
		rst_i <= 1'b1;
		@(posedge sys_clk_i);
		rst_i <= 1'b0;
		exp_q = '{8'h87, 8'h00, 8'h1F, 8'h01, 8'h0F};
		cmp_cfg();
		for (int i = 0; i < 5; i++) bus(1'b0, i, 8'h00, 1'b1);
		report_and_stop();
	end
	// the run needs under 1500 cycles; 4000 leaves room for slow answers
	initial begin
		#200000;
		errors++;
		report_and_stop();
	end
endmodule
